/* File: rtl/redriver_lane_config_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "redriver_cfg.svh"
module redriver_lane_config_ctrl
    import redriver_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_en,
    input wire logic i_reg_mode,
    input wire logic i_swap_strap,
    input wire logic [1:0] i_linear_strap,
    input wire logic [1:0] i_eq_high_strap,
    input wire logic [1:0] i_eq_low_strap,
    input wire logic [1:0] i_curve_map_strap,
    input wire logic i_hotplug_in,
    input wire logic i_frl,
    input wire logic [2:0] i_rate,
    input wire logic i_train_start,
    input wire logic [1:0] i_ffe_level,
    input wire logic i_ltp_ok,
    input wire logic i_over_eq,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_pull_enable,
    output logic o_hotplug_out,
    output logic o_hotplug_oe,
    output logic o_swap,
    output logic o_linear,
    output logic [1:0] o_dc_gain,
    output logic [15:0] o_eq,
    output logic [7:0] o_curve,
    output logic [3:0] o_bypass,
    output logic o_out_enable,
    output logic o_aeq_done
);
    logic en_q_ff;
    logic en_rise;
    logic swap_strap_ff;
    level_t linear_strap_ff;
    logic [3:0] eq_strap_ff;
    level_t map_strap_ff;
    logic [7:0] ctrl_ff;
    logic [15:0] eq_reg_ff;
    logic [15:0] curve_reg_ff;
    logic [2:0] rate_q_ff;
    aeq_state_t state_ff;
    aeq_state_t nxt_state;
    logic [3:0] eq_cur_ff;
    logic [3:0] nxt_eq_cur;
    logic [3:0] eq_applied_ff;
    logic eq_settled;
    logic swap_now;
    logic adaptive_eq_enable_now;
    logic aeq_active;
    logic restart;
    logic hold_now;
    logic linear_now;
    logic [1:0] dcg_now;
    curve_t map_curve;
    logic [3:0] lane_eq [4];
    curve_t lane_curve [4];
    logic [15:0] nxt_eq;
    logic [7:0] nxt_curve;
    logic [3:0] nxt_bypass;

    assign en_rise = i_en && !en_q_ff;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            en_q_ff <= 1'b0;
            o_pull_enable <= 1'b1;
            swap_strap_ff <= 1'b0;
            linear_strap_ff <= LVL_0;
            eq_strap_ff <= 4'h0;
            map_strap_ff <= LVL_0;
        end
        else
        begin
            en_q_ff <= i_en;
            if (en_rise)
            begin
                // Captured values stay until the next rising enable
                swap_strap_ff <= i_swap_strap;
                linear_strap_ff <= level_t'(i_linear_strap);
                map_strap_ff <= level_t'(i_curve_map_strap);
                case (level_t'(i_eq_high_strap))
                    LVL_F: eq_strap_ff[3:2] <= 2'h1;
                    LVL_R: eq_strap_ff[3:2] <= 2'h2;
                    LVL_1: eq_strap_ff[3:2] <= 2'h3;
                    default: eq_strap_ff[3:2] <= 2'h0;
                endcase
                case (level_t'(i_eq_low_strap))
                    LVL_R: eq_strap_ff[1:0] <= 2'h1;
                    LVL_F: eq_strap_ff[1:0] <= 2'h2;
                    LVL_1: eq_strap_ff[1:0] <= 2'h3;
                    default: eq_strap_ff[1:0] <= 2'h0;
                endcase
                o_pull_enable <= 1'b0;
            end
            else if (!i_en)
            begin
                o_pull_enable <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ctrl_ff <= `CTRL_RESET;
            eq_reg_ff <= {`EQ_RESET, `EQ_RESET};
            curve_reg_ff <= {`CURVE_HI_RESET, `CURVE_LO_RESET};
        end
        else if (i_wr)
        begin
            case (i_addr)
                `REG_CTRL: ctrl_ff <= i_wdata;
                `REG_EQ_LO: eq_reg_ff[7:0] <= i_wdata;
                `REG_EQ_HI: eq_reg_ff[15:8] <= i_wdata;
                `REG_CURVE_LO: curve_reg_ff[7:0] <= i_wdata;
                `REG_CURVE_HI: curve_reg_ff[15:8] <= i_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `REG_CTRL: o_rdata <= ctrl_ff;
                `REG_EQ_LO: o_rdata <= eq_reg_ff[7:0];
                `REG_EQ_HI: o_rdata <= eq_reg_ff[15:8];
                `REG_CURVE_LO: o_rdata <= curve_reg_ff[7:0];
                `REG_CURVE_HI: o_rdata <= curve_reg_ff[15:8];
                `REG_STATUS: o_rdata <= {1'b0, o_out_enable, state_ff == AEQ_SCAN, state_ff == AEQ_DONE, eq_cur_ff};
                default: o_rdata <= 8'h00;
            endcase
        end
        else
        begin
            o_rdata <= 8'h00;
        end
    end

    // Hotplug: open drain pulls low only, floats while disabled
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_hotplug_out <= 1'b0;
            o_hotplug_oe <= 1'b0;
        end
        else if (!i_en)
        begin
            o_hotplug_out <= 1'b0;
            o_hotplug_oe <= 1'b0;
        end
        else if (i_reg_mode && ctrl_ff[`CTRL_OPEN_DRAIN])
        begin
            o_hotplug_out <= 1'b0;
            o_hotplug_oe <= !i_hotplug_in;
        end
        else
        begin
            o_hotplug_out <= i_hotplug_in;
            o_hotplug_oe <= 1'b1;
        end
    end

    // Strap mode: adaptation on for map levels R and 1
    assign swap_now = i_reg_mode ? ctrl_ff[`CTRL_SWAP] : swap_strap_ff;
    assign adaptive_eq_enable_now = i_reg_mode ? ctrl_ff[`CTRL_ADAPTIVE_EQ_ENABLE] : map_strap_ff[0];
    assign aeq_active = i_frl && adaptive_eq_enable_now;
    assign restart = aeq_active && (i_train_start || i_rate != rate_q_ff);
    assign hold_now = i_reg_mode ? ctrl_ff[`CTRL_HOLD] : 1'b1;
    // Judge only a setting already on the lanes
    assign eq_settled = eq_applied_ff == eq_cur_ff;
    assign dcg_now = i_reg_mode ? ctrl_ff[`CTRL_DCG_LSB +: 2] : `DCG_BYPASS;

    always_comb
    begin
        if (i_reg_mode)
        begin
            linear_now = ctrl_ff[`CTRL_LINEAR];
        end
        else
        begin
            case (linear_strap_ff)
                LVL_1: linear_now = i_frl;
                LVL_F: linear_now = 1'b1;
                default: linear_now = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        case (map_strap_ff)
            LVL_1: map_curve = CRV_12G;
            LVL_R: map_curve = (i_rate <= 3'h3) ? CRV_6G : CRV_12G;
            default:
            begin
                if (i_rate == 3'h0 || i_rate == 3'h2)
                begin
                    map_curve = CRV_3G;
                end
                else if (i_rate == 3'h1 || i_rate == 3'h3)
                begin
                    map_curve = CRV_6G;
                end
                else
                begin
                    map_curve = CRV_12G;
                end
            end
        endcase
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_eq_cur = eq_cur_ff;
        case (state_ff)
            AEQ_IDLE:
            begin
                if (restart)
                begin
                    nxt_state = AEQ_SCAN;
                    nxt_eq_cur = 4'h0;
                end
            end
            AEQ_SCAN:
            begin
                if (!aeq_active)
                begin
                    nxt_state = AEQ_IDLE;
                end
                else if (restart)
                begin
                    nxt_eq_cur = 4'h0;
                end
                else if (i_ffe_level == 2'h0 && i_ltp_ok && eq_settled)
                begin
                    if (i_over_eq)
                    begin
                        nxt_state = AEQ_DONE;
                        nxt_eq_cur = (eq_cur_ff == 4'h0) ? 4'h0 : eq_cur_ff - 4'h1;
                    end
                    else if (eq_cur_ff == `EQ_MAX)
                    begin
                        nxt_state = AEQ_DONE;
                    end
                    else
                    begin
                        nxt_eq_cur = eq_cur_ff + 4'h1;
                    end
                end
            end
            AEQ_DONE:
            begin
                if (!aeq_active)
                begin
                    nxt_state = AEQ_IDLE;
                end
                else if (restart)
                begin
                    nxt_state = AEQ_SCAN;
                    nxt_eq_cur = 4'h0;
                end
            end
            default: nxt_state = AEQ_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_ff <= AEQ_IDLE;
            eq_cur_ff <= 4'h0;
            eq_applied_ff <= 4'h0;
            rate_q_ff <= 3'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            eq_cur_ff <= nxt_eq_cur;
            eq_applied_ff <= eq_cur_ff;
            rate_q_ff <= i_rate;
        end
    end

    // Settings per input lane: 0 clock when not FRL (data in FRL), 1..3 data
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            always_comb
            begin
                if (aeq_active)
                begin
                    lane_eq[g] = eq_cur_ff;
                end
                else if (g == 0 && !i_frl)
                begin
                    lane_eq[g] = 4'h0;
                end
                else if (i_reg_mode)
                begin
                    lane_eq[g] = eq_reg_ff[4*g +: 4];
                end
                else
                begin
                    lane_eq[g] = eq_strap_ff;
                end
                if (g == 0 && !i_frl)
                begin
                    lane_curve[g] = CRV_3G;
                end
                else if (i_reg_mode)
                begin
                    lane_curve[g] = curve_t'(curve_reg_ff[2*i_rate +: 2]);
                end
                else
                begin
                    lane_curve[g] = map_curve;
                end
            end
            // Output position g takes the lane routed to it
            always_comb
            begin
                nxt_eq[4*g +: 4] = lane_eq[swap_now ? 3 - g : g];
                nxt_curve[2*g +: 2] = lane_curve[swap_now ? 3 - g : g];
                nxt_bypass[g] = i_reg_mode && ctrl_ff[`CTRL_BYPASS] && dcg_now == `DCG_BYPASS
                    && lane_eq[swap_now ? 3 - g : g] == 4'h0;
            end
        end
    endgenerate

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_swap <= 1'b0;
            o_linear <= 1'b0;
            o_dc_gain <= `DCG_BYPASS;
            o_eq <= 16'h0000;
            o_curve <= 8'h00;
            o_bypass <= 4'h0;
            o_out_enable <= 1'b0;
            o_aeq_done <= 1'b0;
        end
        else
        begin
            o_swap <= swap_now;
            o_linear <= linear_now;
            o_dc_gain <= dcg_now;
            o_eq <= nxt_eq;
            o_curve <= nxt_curve;
            o_bypass <= nxt_bypass;
            o_out_enable <= i_en && !(aeq_active && hold_now && nxt_state != AEQ_DONE);
            o_aeq_done <= nxt_state == AEQ_DONE;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    property p_pull_release;
        en_rise |=> !o_pull_enable ##1 (!o_pull_enable || !$past(i_en));
    endproperty
    a_pull_release: assert property (p_pull_release) else $error("pulls not released after capture");

    property p_hotplug_float;
        !i_en |=> !o_hotplug_oe;
    endproperty
    a_hotplug_float: assert property (p_hotplug_float) else $error("hotplug driven while disabled");

    property p_push_pull_strap;
        (i_en && !i_reg_mode) |=> (o_hotplug_oe && o_hotplug_out == $past(i_hotplug_in));
    endproperty
    a_push_pull_strap: assert property (p_push_pull_strap) else $error("strap mode not push-pull");

    property p_strap_hold;
        !en_rise |=> $stable(swap_strap_ff) && $stable(eq_strap_ff);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap value changed without enable rise");

    property p_output_hold;
        (aeq_active && hold_now && nxt_state != AEQ_DONE) |=> !o_out_enable;
    endproperty
    a_output_hold: assert property (p_output_hold) else $error("outputs on before adaptation done");

    property p_no_strap_bypass;
        !i_reg_mode |=> o_bypass == 4'h0;
    endproperty
    a_no_strap_bypass: assert property (p_no_strap_bypass) else $error("bypass in strap mode");

    property p_ffe_freeze;
        (state_ff == AEQ_SCAN && aeq_active && !restart && i_ffe_level != 2'h0) |=> $stable(eq_cur_ff);
    endproperty
    a_ffe_freeze: assert property (p_ffe_freeze) else $error("setting moved at higher FFE level");

    property p_legacy_clock;
        (!i_frl && !swap_now) |=> o_eq[3:0] == 4'h0 && o_curve[1:0] == CRV_3G;
    endproperty
    a_legacy_clock: assert property (p_legacy_clock) else $error("legacy clock lane not zero on 3G");

    property p_over_eq_stop;
        (state_ff == AEQ_SCAN && aeq_active && !restart && i_ffe_level == 2'h0 && i_ltp_ok && eq_settled
            && i_over_eq) |=> state_ff == AEQ_DONE && (o_out_enable || !$past(i_en));
    endproperty
    a_over_eq_stop: assert property (p_over_eq_stop) else $error("scan did not stop on over-equalized");

    c_adapt_done: cover property (state_ff == AEQ_SCAN ##[1:40] state_ff == AEQ_DONE);
    c_swapped: cover property (o_swap && o_out_enable);
    c_open_drain: cover property (o_hotplug_oe && !o_hotplug_out && i_reg_mode);
endmodule : redriver_lane_config_ctrl
`default_nettype wire

/* File: include/redriver_cfg.svh */
`ifndef REDRIVER_CFG_SVH
`define REDRIVER_CFG_SVH
`define REG_CTRL 8'h00
`define REG_EQ_LO 8'h01
`define REG_EQ_HI 8'h02
`define REG_CURVE_LO 8'h03
`define REG_CURVE_HI 8'h04
`define REG_STATUS 8'h05
`define CTRL_SWAP 0
`define CTRL_LINEAR 1
`define CTRL_ADAPTIVE_EQ_ENABLE 2
`define CTRL_HOLD 3
`define CTRL_OPEN_DRAIN 4
`define CTRL_BYPASS 5
`define CTRL_DCG_LSB 6
`define CTRL_RESET 8'h88
`define EQ_RESET 8'h00
`define CURVE_LO_RESET 8'hFF
`define CURVE_HI_RESET 8'h3F
`define DCG_BYPASS 2'h2
`define EQ_MAX 4'hF
`endif

/* File: include/redriver_pkg.sv */
package redriver_pkg;
    typedef enum logic [1:0] {LVL_0 = 2'b00, LVL_R = 2'b01, LVL_F = 2'b10, LVL_1 = 2'b11} level_t;
    typedef enum logic [1:0] {CRV_3G = 2'b01, CRV_6G = 2'b10, CRV_12G = 2'b11} curve_t;
    typedef enum logic [2:0] {AEQ_IDLE = 3'b001, AEQ_SCAN = 3'b010, AEQ_DONE = 3'b100} aeq_state_t;
endpackage : redriver_pkg

/* File: bench/link_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module link_partner
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic i_frl_cmd,
    input wire logic [2:0] i_rate_cmd,
    input wire logic [1:0] i_ffe_cmd,
    input wire logic i_slow,
    input wire logic [3:0] i_target,
    input wire logic [3:0] i_eq_seen,
    output logic o_frl,
    output logic [2:0] o_rate,
    output logic o_train_start,
    output logic [1:0] o_ffe_level,
    output logic o_ltp_ok,
    output logic o_over_eq
);
    // Transmitter side: link mode, rate, training start and pattern flow
    always_ff @(posedge i_clk)
    begin
        o_frl <= i_frl_cmd;
        o_rate <= i_rate_cmd;
        o_train_start <= i_go;
        o_ffe_level <= i_ffe_cmd;
        o_ltp_ok <= i_frl_cmd & (~i_slow | ~o_ltp_ok);
    end
    // Receiver flags the first step past the chosen setting
    assign o_over_eq = o_ltp_ok & (i_eq_seen == i_target + 4'h1);
endmodule : link_partner
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; $display("mismatch at %0t: item %0d got %h expected %h", $time, sel, got, exp); end end
module tb_top;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_en = 1'b0, i_reg_mode = 1'b0, i_swap_strap = 1'b0;
    logic i_hotplug_in = 1'b0, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0, frl_cmd = 1'b0, slow = 1'b0;
    logic [1:0] ffe_cmd = 2'h0, i_linear_strap = 2'h0, i_eq_high_strap = 2'h0;
    logic [1:0] i_eq_low_strap = 2'h0, i_curve_map_strap = 2'h0;
    logic [2:0] rate_cmd = 3'h0;
    logic [3:0] target = 4'h0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
    logic i_frl, i_train_start, i_ltp_ok, i_over_eq;
    logic [2:0] i_rate;
    logic [1:0] i_ffe_level, o_dc_gain, c;
    logic [7:0] o_rdata, o_curve;
    logic o_pull_enable, o_hotplug_out, o_hotplug_oe, o_swap, o_linear, o_out_enable, o_aeq_done;
    logic [15:0] o_eq, exp_v, ev;
    logic [3:0] o_bypass, e;
    logic [15:0] exp_q[$];
    int sel_q[$];
    int n_errors = 0, checked = 0, sel;

    link_partner link_partner_inst (.i_clk, .i_go(go), .i_frl_cmd(frl_cmd), .i_rate_cmd(rate_cmd),
        .i_ffe_cmd(ffe_cmd), .i_slow(slow), .i_target(target), .i_eq_seen(o_eq[7:4]), .o_frl(i_frl),
        .o_rate(i_rate), .o_train_start(i_train_start), .o_ffe_level(i_ffe_level),
        .o_ltp_ok(i_ltp_ok), .o_over_eq(i_over_eq));
    redriver_lane_config_ctrl redriver_lane_config_ctrl_inst (.i_clk, .i_sys_rst, .i_en, .i_reg_mode,
        .i_swap_strap, .i_linear_strap, .i_eq_high_strap, .i_eq_low_strap, .i_curve_map_strap, .i_hotplug_in,
        .i_frl, .i_rate, .i_train_start, .i_ffe_level, .i_ltp_ok, .i_over_eq, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .o_pull_enable, .o_hotplug_out, .o_hotplug_oe, .o_swap, .o_linear, .o_dc_gain, .o_eq,
        .o_curve, .o_bypass, .o_out_enable, .o_aeq_done);

    initial forever #20 i_clk = ~i_clk;

    function automatic logic [15:0] observe(input int s);
        case (s)
            0: return {8'h00, o_rdata};
            1: return {15'h0000, o_pull_enable};
            2: return {14'h0000, o_hotplug_oe, o_hotplug_out};
            3: return {8'h00, o_swap, o_linear, o_dc_gain, o_bypass};
            4: return o_eq;
            5: return {8'h00, o_curve};
            6: return {14'h0000, o_aeq_done, o_out_enable};
            default: return {15'h0000, o_hotplug_oe};
        endcase
    endfunction : observe

    function automatic logic [3:0] eq_of(input logic [1:0] hi, input logic [1:0] lo);
        logic [3:0] h;
        h = (hi == 2'b01) ? 4'h8 : (hi == 2'b10) ? 4'h4 : {hi, 2'b00};
        return h + {2'b00, lo};
    endfunction : eq_of

    function automatic logic [1:0] curve_of(input logic [1:0] m, input logic [2:0] r);
        if (m == 2'b11 || r > 3'h3)
            return 2'b11;
        if (m == 2'b01)
            return 2'b10;
        return r[0] ? 2'b10 : 2'b01;
    endfunction : curve_of

    task automatic expect_out(input int s, input logic [15:0] v);
        sel_q.push_back(s);
        exp_q.push_back(v);
    endtask : expect_out

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : wait_cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data is judged in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        expect_out(0, {8'h00, d});
    endtask : rd

    task automatic adapt(input logic [3:0] t, input logic s, input logic [2:0] r, input logic g,
                         input logic [15:0] mid);
        @(posedge i_clk);
        target <= t;
        slow <= s;
        rate_cmd <= r;
        go <= g;
        @(posedge i_clk);
        go <= 1'b0;
        wait_cyc(3);
        expect_out(6, mid);
        for (int k = 0; k < 200 && o_aeq_done !== 1'b1; k++) @(posedge i_clk);
        expect_out(6, 16'h0003);
        expect_out(4, {4{t}});
        rd(8'h05, {4'h5, t});
    endtask : adapt

    task automatic results();
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    always @(negedge i_clk)
    begin
        while (exp_q.size() > 0)
        begin
            sel = sel_q.pop_front();
            exp_v = exp_q.pop_front();
            `CHK(observe(sel), exp_v)
        end
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        results();
    end

    initial
    begin
        void'($urandom(38777));
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        expect_out(1, 16'h0001);
        expect_out(3, 16'h0020);
        expect_out(2, 16'h0000);
        repeat (6)
        begin
            @(posedge i_clk);
            i_en <= 1'b0;
            i_hotplug_in <= 1'($urandom);
            rate_cmd <= {2'b00, 1'($urandom)};
            {i_swap_strap, i_linear_strap, i_eq_high_strap, i_eq_low_strap, i_curve_map_strap} <= 9'($urandom);
            wait_cyc(3);
            expect_out(1, 16'h0001);
            expect_out(2, 16'h0000);
            @(posedge i_clk);
            i_en <= 1'b1;
            wait_cyc(3);
            e = eq_of(i_eq_high_strap, i_eq_low_strap);
            c = curve_of(i_curve_map_strap, i_rate);
            ev = i_swap_strap ? {4'h0, e, e, e} : {e, e, e, 4'h0};
            expect_out(4, ev);
            expect_out(5, {8'h00, i_swap_strap ? {2'b01, c, c, c} : {c, c, c, 2'b01}});
            expect_out(3, {8'h00, i_swap_strap, i_linear_strap == 2'b10, 6'h20});
            expect_out(1, 16'h0000);
            expect_out(2, {14'h0000, 1'b1, i_hotplug_in});
            i_eq_high_strap <= ~i_eq_high_strap;
            i_eq_low_strap <= ~i_eq_low_strap;
            wait_cyc(3);
            expect_out(4, ev);
        end
        i_reg_mode <= 1'b1;
        frl_cmd <= 1'b1;
        rate_cmd <= 3'h3;
        rd(8'h00, 8'h88);
        rd(8'h01, 8'h00);
        rd(8'h03, 8'hFF);
        rd(8'h04, 8'h3F);
        rd(8'h3C, 8'h00);
        ev = 16'($urandom) & 16'hF0FF;
        wr(8'h01, ev[7:0]);
        wr(8'h02, ev[15:8]);
        wr(8'h03, 8'h7F);
        wr(8'h00, 8'hA2);
        wait_cyc(3);
        expect_out(4, ev);
        expect_out(5, 16'h0055);
        expect_out(3, {8'h00, 4'b0110, ev[15:12] == 4'h0, 1'b1, ev[7:4] == 4'h0, ev[3:0] == 4'h0});
        wr(8'h00, 8'hA3);
        wait_cyc(3);
        expect_out(4, {ev[3:0], ev[7:4], ev[11:8], ev[15:12]});
        expect_out(3, {8'h00, 4'b1110, ev[3:0] == 4'h0, ev[7:4] == 4'h0, 1'b1, ev[15:12] == 4'h0});
        wr(8'h00, 8'h10);
        i_hotplug_in <= 1'b0;
        wait_cyc(3);
        expect_out(2, 16'h0002);
        i_hotplug_in <= 1'b1;
        wait_cyc(3);
        expect_out(7, 16'h0000);
        rd(8'h00, 8'h10);
        wr(8'h00, 8'h8C);
        e = 4'($urandom_range(14, 3));
        adapt(e, 1'b0, 3'h3, 1'b1, 16'h0000);
        ffe_cmd <= 2'h1;
        target <= e - 4'h1;
        wait_cyc(5);
        expect_out(4, {4{e}});
        ffe_cmd <= 2'h0;
        adapt(4'($urandom_range(14, 3)), 1'b1, 3'h4, 1'b0, 16'h0000);
        frl_cmd <= 1'b0;
        rate_cmd <= 3'h0;
        wait_cyc(4);
        expect_out(4, {ev[15:4], 4'h0});
        expect_out(5, 16'h00FD);
        wr(8'h00, 8'h84);
        frl_cmd <= 1'b1;
        adapt(4'($urandom_range(14, 3)), 1'b0, 3'h5, 1'b1, 16'h0001);
        wait_cyc(2);
        results();
    end
endmodule : tb_top
`default_nettype wire
